// ==== core/clear_ops.sv ====
// Bit clear and watchdog clear instruction execution
//
// Operation
// - Bit clear forces only the chosen memory bit to 0; flags untouched.
// - Single watchdog clear zeroes counter, timeout flag and power-down flag.
// - First paired half clears counter and both flags only after second half.
// - Repeated first halves without a second in between do nothing.
// - Second paired half behaves the same, alternating with the first half.
`timescale 1ns/100ps
module clear_ops
   import clear_ops_pkg::*;
#(
   parameter int WDT_BITS = WDT_W
) (
   input  wire logic                  i_clk,              // System clock
   input  wire logic                  i_rst_n,            // Async reset, active low
   input  wire logic                  i_op_valid,         // Instruction execute strobe
   input  wire op_t                   i_op,               // Instruction selector
   input  wire logic [MEM_ADDR_W-1:0] i_op_addr,          // Memory address for bit clear
   input  wire logic [BIT_IDX_W-1:0]  i_op_bit,           // Bit index for bit clear
   input  wire logic                  i_power_down,       // Core enters power down
   input  wire logic                  i_wr_en,            // Core memory write strobe
   input  wire logic [MEM_ADDR_W-1:0] i_wr_addr,          // Core memory write address
   input  wire logic [DATA_W-1:0]     i_wr_data,          // Core memory write data
   input  wire logic [MEM_ADDR_W-1:0] i_rd_addr,          // Core memory read address
   output logic      [DATA_W-1:0]     o_rd_data,          // Memory read data, next cycle
   output logic                       o_busy,             // Bit clear write-back cycle
   output logic      [WDT_BITS-1:0]   o_watchdog_counter, // Watchdog count
   output logic                       o_watchdog_timeout_flag, // Timeout flag
   output logic                       o_power_down_flag,  // Power-down flag
   output logic                       o_wdt_cleared       // Pulse after effective clear
);
   localparam logic [WDT_BITS-1:0] WDT_ZERO = '0;
   localparam logic [WDT_BITS-1:0] WDT_ONE  = {{(WDT_BITS-1){1'b0}}, 1'b1};
   localparam logic [WDT_BITS-1:0] WDT_MAX  = '1;

   logic                  busy_q,    busy_d;
   logic [MEM_ADDR_W-1:0] addr_q,    addr_d;
   logic [BIT_IDX_W-1:0]  bit_q,     bit_d;
   half_t                 last_q,    last_d;
   logic [WDT_BITS-1:0]   wdt_q,     wdt_d;
   logic                  tmo_q,     tmo_d;
   logic                  pwd_q,     pwd_d;
   logic                  clr_q,     clr_d;
   logic                  accept;
   logic                  do_bit_clear;
   logic                  do_pair_first;
   logic                  do_pair_second;
   logic                  wdt_clear;
   logic                  tmo_event;
   logic                  mem_wr_en;
   logic [MEM_ADDR_W-1:0] mem_wr_addr;
   logic [DATA_W-1:0]     mem_wr_data;
   logic [MEM_ADDR_W-1:0] mem_rd_addr;
   logic [DATA_W-1:0]     mem_rd_data;

   // One-hot mask selecting a bit of a byte
   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IDX_W-1:0] idx);
      logic [DATA_W-1:0] m;
      m = '0;
      m[idx] = 1'b1;
      return m;
   endfunction : bit_mask

   // Instructions are refused during the write-back cycle
   assign accept         = i_op_valid && !busy_q;
   assign do_bit_clear   = accept && (i_op == OP_MEMORY_BIT_CLEAR);
   assign do_pair_first  = accept && (i_op == OP_PAIRED_CLEAR_FIRST_HALF);
   assign do_pair_second = accept && (i_op == OP_PAIRED_CLEAR_SECOND_HALF);
   assign tmo_event      = (wdt_q == WDT_MAX);

   always_comb begin
      busy_d      = do_bit_clear;
      addr_d      = do_bit_clear ? i_op_addr : addr_q;
      bit_d       = do_bit_clear ? i_op_bit : bit_q;
      mem_rd_addr = do_bit_clear ? i_op_addr : i_rd_addr;
      mem_wr_en   = busy_q || (i_wr_en && !do_bit_clear);
      mem_wr_addr = busy_q ? addr_q : i_wr_addr;
      mem_wr_data = busy_q ? (mem_rd_data & ~bit_mask(bit_q)) : i_wr_data;
   end

   // Alternation record and effective clear decode
   always_comb begin
      last_d    = last_q;
      wdt_clear = 1'b0;
      unique case (1'b1)
         accept && (i_op == OP_SINGLE_WATCHDOG_CLEAR): begin
            wdt_clear = 1'b1;
         end
         do_pair_first: begin
            // Effective only after the second half
            wdt_clear = (last_q == HALF_SECOND);
            last_d    = HALF_FIRST;
         end
         do_pair_second: begin
            // Effective only after the first half
            wdt_clear = (last_q == HALF_FIRST);
            last_d    = HALF_SECOND;
         end
         default: begin
            wdt_clear = 1'b0;
         end
      endcase
   end

   // Watchdog counter and flags; a hardware set wins over a clear
   always_comb begin
      wdt_d = wdt_clear ? WDT_ZERO : wdt_q + WDT_ONE;
      tmo_d = tmo_event ? 1'b1 : (wdt_clear ? FLAG_CLEARED : tmo_q);
      pwd_d = i_power_down ? 1'b1 : (wdt_clear ? FLAG_CLEARED : pwd_q);
      clr_d = wdt_clear;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q <= 1'b0;
         addr_q <= '0;
         bit_q  <= '0;
         last_q <= LAST_HALF_RST;
         wdt_q  <= '0;
         tmo_q  <= FLAG_RST;
         pwd_q  <= FLAG_RST;
         clr_q  <= 1'b0;
      end else begin
         busy_q <= busy_d;
         addr_q <= addr_d;
         bit_q  <= bit_d;
         last_q <= last_d;
         wdt_q  <= wdt_d;
         tmo_q  <= tmo_d;
         pwd_q  <= pwd_d;
         clr_q  <= clr_d;
      end
   end

   data_mem #(
      .DEPTH  (MEM_DEPTH),
      .ADDR_W (MEM_ADDR_W),
      .WIDTH  (DATA_W)
   ) u_mem (
      .i_clk     (i_clk),
      .i_wr_en   (mem_wr_en),
      .i_wr_addr (mem_wr_addr),
      .i_wr_data (mem_wr_data),
      .i_rd_addr (mem_rd_addr),
      .o_rd_data (mem_rd_data)
   );

   assign o_rd_data               = mem_rd_data;
   assign o_busy                  = busy_q;
   assign o_watchdog_counter      = wdt_q;
   assign o_watchdog_timeout_flag = tmo_q;
   assign o_power_down_flag       = pwd_q;
   assign o_wdt_cleared           = clr_q;

   a_bit_clear_value: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      busy_q |-> mem_wr_en && (mem_wr_addr == addr_q) && (mem_wr_data[bit_q] == BIT_CLEARED)
         && ((mem_wr_data | bit_mask(bit_q)) == (mem_rd_data | bit_mask(bit_q))))
      else $error("bit clear changed the wrong bits");

   a_bit_clear_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      do_bit_clear && !tmo_event && !i_power_down |=> $stable(tmo_q) && $stable(pwd_q)
         && !clr_q ##1 !busy_q)
      else $error("bit clear disturbed flags or sequence");

   a_single_clear_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      accept && (i_op == OP_SINGLE_WATCHDOG_CLEAR) && !tmo_event && !i_power_down
         |=> (wdt_q == WDT_ZERO) && !tmo_q && !pwd_q && clr_q
         ##1 (clr_q || (wdt_q == WDT_ONE)))
      else $error("single watchdog clear did not clear");

   a_first_half_takes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      do_pair_first && (last_q == HALF_SECOND) && !i_power_down && !tmo_event
         |=> (wdt_q == WDT_ZERO) && !pwd_q && !tmo_q)
      else $error("alternating first half had no effect");

   a_first_half_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      do_pair_first && (last_q == HALF_FIRST)
         |=> (wdt_q == $past(wdt_q) + WDT_ONE) && !clr_q && (pwd_q || !$past(pwd_q)))
      else $error("repeated first half took effect");

   a_second_half_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      do_pair_second |=> (clr_q == ($past(last_q) == HALF_FIRST))
         && ((wdt_q == WDT_ZERO) || ($past(last_q) == HALF_SECOND)))
      else $error("second half alternation wrong");

   a_last_half_rec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (do_pair_first || do_pair_second)
         |=> (last_q == ($past(do_pair_first) ? HALF_FIRST : HALF_SECOND)))
      else $error("paired half record not updated");

   a_no_clear_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !accept |=> !clr_q && $stable(last_q))
      else $error("clear without instruction");

   a_bit_clear_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      do_bit_clear |=> busy_q && (addr_q == $past(i_op_addr)) && (bit_q == $past(i_op_bit)))
      else $error("bit clear target not captured");

   a_busy_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      busy_q |=> !busy_q)
      else $error("write-back cycle too long");

   a_counter_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !wdt_clear |=> (wdt_q == $past(wdt_q) + WDT_ONE))
      else $error("watchdog counter did not advance");

   a_cleared_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      clr_q |-> (wdt_q == WDT_ZERO))
      else $error("clear pulse without zero count");

   a_timeout_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      tmo_event |=> tmo_q)
      else $error("timeout flag not set");

   a_power_down_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_power_down |=> pwd_q)
      else $error("power-down flag not set");

   a_timeout_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !wdt_clear && !tmo_event |=> $stable(tmo_q))
      else $error("timeout flag changed without cause");

   a_power_down_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !wdt_clear && !i_power_down |=> $stable(pwd_q))
      else $error("power-down flag changed without cause");
endmodule : clear_ops

// ==== core/clear_ops_pkg.sv ====
// Shared constants and types for the clear-type instruction block
package clear_ops_pkg;
   // Instruction selector presented by the core sequencer
   typedef enum logic [2:0] {
      OP_NONE,
      OP_MEMORY_BIT_CLEAR,
      OP_SINGLE_WATCHDOG_CLEAR,
      OP_PAIRED_CLEAR_FIRST_HALF,
      OP_PAIRED_CLEAR_SECOND_HALF
   } op_t;

   // Which paired half ran last
   typedef enum logic {
      HALF_FIRST,
      HALF_SECOND
   } half_t;

   localparam int    DATA_W         = 8;
   localparam int    BIT_IDX_W      = 3;
   localparam int    MEM_DEPTH      = 128;
   localparam int    MEM_ADDR_W     = 7;
   localparam int    WDT_W          = 8;
   localparam half_t LAST_HALF_RST  = HALF_SECOND;
   localparam logic  FLAG_RST       = 1'h0;
   localparam logic  FLAG_CLEARED   = 1'h0;
   localparam logic  BIT_CLEARED    = 1'h0;
endpackage : clear_ops_pkg

// ==== core/data_mem.sv ====
// Small data memory with registered read data
`timescale 1ns/100ps
module data_mem
   import clear_ops_pkg::*;
#(
   parameter int DEPTH  = MEM_DEPTH,
   parameter int ADDR_W = MEM_ADDR_W,
   parameter int WIDTH  = DATA_W
) (
   input  wire logic              i_clk,      // System clock
   input  wire logic              i_wr_en,    // Write strobe
   input  wire logic [ADDR_W-1:0] i_wr_addr,  // Write address
   input  wire logic [WIDTH-1:0]  i_wr_data,  // Write data
   input  wire logic [ADDR_W-1:0] i_rd_addr,  // Read address
   output logic      [WIDTH-1:0]  o_rd_data   // Registered read data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_wr_en) begin
         mem_q[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem_q[i_rd_addr];
   end
endmodule : data_mem

// ==== dv/clear_ops_tb.sv ====
// Self-checking bench for the clear-type instruction block
`timescale 1ns/100ps
module clear_ops_tb;
   import clear_ops_pkg::*;
   localparam int WB = 4;
   logic                  i_clk = 1'b0;
   logic                  i_rst_n = 1'b0;
   logic                  i_op_valid = 1'b0;
   op_t                   i_op = OP_NONE;
   logic [MEM_ADDR_W-1:0] i_op_addr = '0;
   logic [BIT_IDX_W-1:0]  i_op_bit = '0;
   logic                  i_power_down = 1'b0;
   logic                  i_wr_en = 1'b0;
   logic [MEM_ADDR_W-1:0] i_wr_addr = '0;
   logic [DATA_W-1:0]     i_wr_data = '0;
   logic [MEM_ADDR_W-1:0] i_rd_addr = '0;
   logic [DATA_W-1:0]     o_rd_data;
   logic                  o_busy;
   logic [WB-1:0]         o_watchdog_counter;
   logic                  o_watchdog_timeout_flag;
   logic                  o_power_down_flag;
   logic                  o_wdt_cleared;
   logic                  rd_tag = 1'b0;
   logic                  rd_seen = 1'b0;
   logic [WB+1:0]         clr_q[$];
   logic [DATA_W:0]       mem_q[$];
   logic [1:0]            busy_note[$];
   logic [WB+1:0]         clr_got;
   logic [1:0]            busy_got;
   int                    fails = 0;
   int                    checked = 0;
   op_t                   seq[8] = '{OP_PAIRED_CLEAR_SECOND_HALF, OP_PAIRED_CLEAR_FIRST_HALF,
      OP_PAIRED_CLEAR_FIRST_HALF, OP_PAIRED_CLEAR_SECOND_HALF, OP_PAIRED_CLEAR_SECOND_HALF,
      OP_PAIRED_CLEAR_FIRST_HALF, OP_SINGLE_WATCHDOG_CLEAR, OP_PAIRED_CLEAR_SECOND_HALF};
   logic [0:7]            eff = 8'h57;
   logic [DATA_W-1:0]     d;
   logic [MEM_ADDR_W-1:0] a;
   logic [BIT_IDX_W-1:0]  b;

   clear_ops #(.WDT_BITS(WB)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
      .i_op(i_op), .i_op_addr(i_op_addr), .i_op_bit(i_op_bit), .i_power_down(i_power_down),
      .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
      .o_rd_data(o_rd_data), .o_busy(o_busy), .o_watchdog_counter(o_watchdog_counter),
      .o_watchdog_timeout_flag(o_watchdog_timeout_flag), .o_power_down_flag(o_power_down_flag),
      .o_wdt_cleared(o_wdt_cleared));

   always #4 i_clk = ~i_clk;

   assign clr_got  = {o_watchdog_timeout_flag, o_power_down_flag, o_watchdog_counter};
   assign busy_got = {o_busy, o_wdt_cleared};

   task automatic cmp(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic cmp_clr(input logic [WB+1:0] got, input logic [WB+1:0] exp);
      cmp((DATA_W+1)'(got), (DATA_W+1)'(exp));
   endtask : cmp_clr

   task automatic cmp_busy(input logic [1:0] got, input logic [1:0] exp);
      cmp((DATA_W+1)'(got), (DATA_W+1)'(exp));
   endtask : cmp_busy

   task automatic cmp_mem(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
      cmp(got, exp);
   endtask : cmp_mem

   task automatic tally_and_finish;
      fails += clr_q.size() + mem_q.size() + busy_note.size();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic op(input op_t o, input logic e, input logic [MEM_ADDR_W-1:0] ad = '0,
                     input logic [BIT_IDX_W-1:0] bi = '0);
      i_op_valid = 1'b1;
      i_op = o;
      i_op_addr = ad;
      i_op_bit = bi;
      if (e) clr_q.push_back('0);
      @(negedge i_clk);
   endtask : op

   task automatic idle(input int n);
      i_op_valid = 1'b0;
      repeat (n) @(negedge i_clk);
   endtask : idle

   // Result watcher: oldest note against each result
   always @(posedge i_clk) rd_seen <= rd_tag;
   always @(negedge i_clk) begin
      if (o_wdt_cleared === 1'b1)
         cmp_clr(clr_got, clr_q.size() ? clr_q.pop_front() : 6'h3F);
      if (o_busy === 1'b1)
         cmp_busy(busy_got, busy_note.size() ? busy_note.pop_front() : 2'h3);
      if (rd_seen) cmp_mem({o_power_down_flag, o_rd_data}, mem_q.pop_front());
   end

   initial begin
      repeat (3000) @(posedge i_clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(96142));
      repeat (16) @(negedge i_clk);
      i_rst_n = 1'b1;
      for (int k = 0; k < 8; k++) op(seq[k], eff[k]);
      idle(2);
      i_power_down = 1'b1;
      for (int k = 0; k < 40 && o_watchdog_timeout_flag !== 1'b1; k++) idle(1);
      i_power_down = 1'b0;
      if (o_watchdog_timeout_flag !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
      op(OP_SINGLE_WATCHDOG_CLEAR, 1'b1);
      idle(2);
      for (int k = 0; k < 4; k++) begin
         d = DATA_W'($urandom);
         a = MEM_ADDR_W'($urandom);
         b = BIT_IDX_W'($urandom);
         i_wr_en = 1'b1;
         i_wr_addr = a;
         i_wr_data = d;
         i_power_down = 1'b1;
         @(negedge i_clk);
         i_wr_en = 1'b0;
         i_power_down = 1'b0;
         // Bit clear, refused op while busy
         busy_note.push_back(2'h2);
         op(OP_MEMORY_BIT_CLEAR, 1'b0, a, b);
         op(OP_SINGLE_WATCHDOG_CLEAR, 1'b0);
         idle(1);
         i_rd_addr = a;
         rd_tag = 1'b1;
         mem_q.push_back({1'b1, d & ~(8'h01 << b)});
         @(negedge i_clk);
         rd_tag = 1'b0;
         idle(2);
      end
      tally_and_finish();
   end
endmodule : clear_ops_tb
